// ### design/isx_core.sv
// execute block for increment-skip, or-immediate and or-register
// assumes instr_i comes from same-clock fetch logic and is valid in q1
//
// Local design decisions: the placing of the registers and strobed register access.
module isx_core
(
    input wire logic core_clk_i,
    input wire logic rst_i,
    input wire logic [13:0] instr_i, // instruction presented for q1
    input wire logic [7:0] reg_addr_i, // register bus address
    input wire logic [7:0] reg_wdata_i, // register bus write data
    input wire logic reg_wr_i, // write strobe
    input wire logic reg_rd_i, // read strobe
    output logic [7:0] reg_rdata_o, // read data, cycle after strobe
    output logic [1:0] phase_o, // current q phase
    output logic [7:0] acc_o, // accumulator
    output logic zero_o, // zero flag
    output logic skip_o // current cycle is a forced no-op
);
    ////////////////////////////////////////////////////////////////////////
    // state
    typedef struct packed
    {
        isx_pkg::isx_phase_e phase; // q phase
        logic [13:0] ir; // instruction being executed
        isx_pkg::isx_op_e op; // decoded operation
        logic skip_pend; // next cycle is to be discarded
        logic skipping; // this cycle is discarded
        logic [7:0] opnd; // operand read in q2
        logic [7:0] result; // result from q3
        logic res_zero; // zero of result
        logic [7:0] acc; // accumulator
        logic zero; // zero flag
        logic [7:0] rdata; // bus read data
        logic [127:0][7:0] file; // file registers
    } isx_state_s;

    isx_state_s st_r; // registered state
    isx_state_s st_nxt; // next state
    isx_if alu_bus (); // link to arithmetic unit

    logic [5:0] opc; // opcode field of ir
    logic dest_f; // result goes to file register
    logic [6:0] faddr; // file address field
    logic [7:0] lit; // literal field
    logic [5:0] instr_opc; // opcode field of the word being taken

    assign opc = st_r.ir[isx_pkg::OPC_MSB:isx_pkg::OPC_LSB];
    assign dest_f = st_r.ir[isx_pkg::DEST_BIT];
    assign faddr = st_r.ir[isx_pkg::FADDR_MSB:0];
    assign lit = st_r.ir[isx_pkg::LIT_MSB:0];
    assign instr_opc = instr_i[isx_pkg::OPC_MSB:isx_pkg::OPC_LSB];

    // operands to the arithmetic unit
    assign alu_bus.op = st_r.op;
    assign alu_bus.acc = st_r.acc;
    assign alu_bus.opnd = st_r.opnd;

    isx_alu u_alu
    (
        .bus(alu_bus)
    );

    ////////////////////////////////////////////////////////////////////////
    // next-state logic
    always_comb
    begin
        st_nxt = st_r;
        // bus writes first, so a q4 write of the instruction wins
        if (reg_wr_i)
        begin
            if (reg_addr_i <= isx_pkg::ADDR_FILE_LAST)
            begin
                st_nxt.file[reg_addr_i[6:0]] = reg_wdata_i;
            end
            else if (reg_addr_i == isx_pkg::ADDR_ACC)
            begin
                st_nxt.acc = reg_wdata_i;
            end
            else if (reg_addr_i == isx_pkg::ADDR_STATUS)
            begin
                st_nxt.zero = reg_wdata_i[isx_pkg::ST_ZERO];
            end
            else
            begin
                // unmapped or read-only: ignored
            end
        end
        // bus read, data stands in the next cycle only
        if (reg_rd_i)
        begin
            if (reg_addr_i <= isx_pkg::ADDR_FILE_LAST)
            begin
                st_nxt.rdata = st_r.file[reg_addr_i[6:0]];
            end
            else
            begin
                case (reg_addr_i)
                    isx_pkg::ADDR_ACC: st_nxt.rdata = st_r.acc;
                    isx_pkg::ADDR_STATUS:
                        st_nxt.rdata = {6'h00, st_r.skipping, st_r.zero};
                    isx_pkg::ADDR_INSTR_LO: st_nxt.rdata = st_r.ir[7:0];
                    isx_pkg::ADDR_INSTR_HI: st_nxt.rdata = {2'h0, st_r.ir[13:8]};
                    default: st_nxt.rdata = 8'h00;
                endcase
            end
        end
        else
        begin
            st_nxt.rdata = 8'h00;
        end
        // four-phase sequencer
        case (st_r.phase)
            isx_pkg::PH_Q1:
            begin
                // decode; a pending skip turns the word into a no-op
                st_nxt.phase = isx_pkg::PH_Q2;
                st_nxt.ir = instr_i;
                st_nxt.skipping = st_r.skip_pend; // see [RULE3]
                st_nxt.skip_pend = 1'b0;
                if (st_r.skip_pend)
                begin
                    st_nxt.op = isx_pkg::OP_NOP; // see [RULE4]
                end
                else if (instr_opc == isx_pkg::OPC_INC_SKIP)
                begin
                    st_nxt.op = isx_pkg::OP_INC_SKIP; // see [RULE1]
                end
                else if (instr_opc == isx_pkg::OPC_OR_IMM)
                begin
                    st_nxt.op = isx_pkg::OP_OR_IMM; // see [RULE5]
                end
                else if (instr_opc == isx_pkg::OPC_OR_REG)
                begin
                    st_nxt.op = isx_pkg::OP_OR_REG; // see [RULE8]
                end
                else
                begin
                    st_nxt.op = isx_pkg::OP_NOP; // other words not handled here
                end
            end
            isx_pkg::PH_Q2:
            begin
                // read register or literal
                st_nxt.phase = isx_pkg::PH_Q3;
                case (st_r.op)
                    isx_pkg::OP_INC_SKIP: st_nxt.opnd = st_r.file[faddr]; // see [RULE4]
                    isx_pkg::OP_OR_REG: st_nxt.opnd = st_r.file[faddr];
                    isx_pkg::OP_OR_IMM: st_nxt.opnd = lit; // see [RULE7]
                    default: st_nxt.opnd = st_r.opnd;
                endcase
            end
            isx_pkg::PH_Q3:
            begin
                // compute
                st_nxt.phase = isx_pkg::PH_Q4;
                st_nxt.result = alu_bus.result;
                st_nxt.res_zero = alu_bus.zero;
            end
            isx_pkg::PH_Q4:
            begin
                // write destination
                st_nxt.phase = isx_pkg::PH_Q1;
                case (st_r.op)
                    isx_pkg::OP_INC_SKIP:
                    begin
                        if (dest_f)
                        begin
                            st_nxt.file[faddr] = st_r.result; // see [RULE2]
                        end
                        else
                        begin
                            st_nxt.acc = st_r.result; // see [RULE2]
                        end
                        st_nxt.skip_pend = st_r.res_zero; // see [RULE3]
                    end
                    isx_pkg::OP_OR_IMM:
                    begin
                        st_nxt.acc = st_r.result; // see [RULE6]
                        st_nxt.zero = st_r.res_zero; // see [RULE10]
                    end
                    isx_pkg::OP_OR_REG:
                    begin
                        if (dest_f)
                        begin
                            st_nxt.file[faddr] = st_r.result; // see [RULE9]
                        end
                        else
                        begin
                            st_nxt.acc = st_r.result; // see [RULE9]
                        end
                        st_nxt.zero = st_r.res_zero; // see [RULE10]
                    end
                    default:
                    begin
                        // no-op: nothing written
                    end
                endcase
            end
            default: st_nxt.phase = isx_pkg::PH_Q1;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    // state register
    always_ff @(posedge core_clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            st_r <= '0;
            st_r.phase <= isx_pkg::PH_Q1;
            st_r.op <= isx_pkg::OP_NOP;
            st_r.ir <= isx_pkg::RST_INSTR;
            st_r.acc <= isx_pkg::RST_ACC;
        end
        else
        begin
            st_r <= st_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // outputs straight from state
    assign reg_rdata_o = st_r.rdata;
    assign phase_o = st_r.phase;
    assign acc_o = st_r.acc;
    assign zero_o = st_r.zero;
    assign skip_o = st_r.skipping;
endmodule : isx_core

// ### common/isx_pkg.sv
// constants, types and field layout of the three-instruction execute block
// assumes one core clock; the q-phase counter is kept inside the core
// Operation
// [RULE1] increment-skip opcode 00 1111, d bit, f address
// [RULE2] increment f, route by d, no flags
// [RULE3] zero result discards next instruction, two cycles
// [RULE4] phases: decode, read f, compute, write
// [RULE5] or-immediate opcode 11 1000 with 8-bit literal
// [RULE6] accumulator or literal into accumulator, zero updated
// [RULE7] or-immediate completes in one instruction cycle
// [RULE8] or-register opcode 00 0100, d bit, f address
// [RULE9] accumulator or f, route by d, zero updated
// [RULE10] zero flag set exactly when result is zero
package isx_pkg;
    // opcode fields, bits 13:8 of the instruction word
    localparam logic [5:0] OPC_INC_SKIP = 6'h0f;
    localparam logic [5:0] OPC_OR_IMM = 6'h38;
    localparam logic [5:0] OPC_OR_REG = 6'h04;
    localparam int OPC_MSB = 13;
    localparam int OPC_LSB = 8;
    localparam int DEST_BIT = 7;
    localparam int FADDR_MSB = 6;
    localparam int LIT_MSB = 7;
    // register bus map, byte addresses
    localparam logic [7:0] ADDR_FILE_LAST = 8'h7f;
    localparam logic [7:0] ADDR_ACC = 8'h80;
    localparam logic [7:0] ADDR_STATUS = 8'h81;
    localparam logic [7:0] ADDR_INSTR_LO = 8'h82;
    localparam logic [7:0] ADDR_INSTR_HI = 8'h83;
    // status register bit positions
    localparam int ST_ZERO = 0;
    localparam int ST_SKIP = 1;
    // reset values
    localparam logic [7:0] RST_ACC = 8'h00;
    localparam logic [13:0] RST_INSTR = 14'h0000;
    // decoded operation
    typedef enum logic [1:0]
    {
        OP_NOP = 2'b00,
        OP_INC_SKIP = 2'b01,
        OP_OR_IMM = 2'b10,
        OP_OR_REG = 2'b11
    } isx_op_e;
    // four phases of one instruction cycle
    typedef enum logic [1:0]
    {
        PH_Q1 = 2'b00,
        PH_Q2 = 2'b01,
        PH_Q3 = 2'b10,
        PH_Q4 = 2'b11
    } isx_phase_e;
endpackage : isx_pkg

// ### common/isx_if.sv
// operand and result bundle between the core and its arithmetic unit
// assumes both ends sit in the same clock domain
interface isx_if;
    isx_pkg::isx_op_e op; // operation to perform
    logic [7:0] acc; // accumulator operand
    logic [7:0] opnd; // register or literal operand
    logic [7:0] result; // computed value
    logic zero; // result equals zero
    modport core (output op, output acc, output opnd, input result, input zero);
    modport alu (input op, input acc, input opnd, output result, output zero);
endinterface : isx_if

// ### design/isx_alu.sv
// combinational arithmetic for increment and inclusive or
// assumes operands are held stable by the core during the compute phase
module isx_alu
(
    isx_if.alu bus
);
    ////////////////////////////////////////////////////////////////////////
    // result select and zero detect
    always_comb
    begin
        case (bus.op)
            isx_pkg::OP_INC_SKIP: bus.result = bus.opnd + 8'h01; // see [RULE2]
            isx_pkg::OP_OR_IMM: bus.result = bus.acc | bus.opnd; // see [RULE6]
            isx_pkg::OP_OR_REG: bus.result = bus.acc | bus.opnd; // see [RULE9]
            default: bus.result = 8'h00;
        endcase
        bus.zero = (bus.result == 8'h00); // see [RULE10]
    end
endmodule : isx_alu

// ### bench/isx_monitor.sv
// checker for the three-instruction execute block
// assumes it is bound to isx_core and sees only its ports
module isx_monitor
(
    input wire logic core_clk_i,
    input wire logic rst_i,
    input wire logic [13:0] instr_i,
    input wire logic [7:0] reg_addr_i,
    input wire logic [7:0] reg_wdata_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    input wire logic [7:0] reg_rdata_o,
    input wire logic [1:0] phase_o,
    input wire logic [7:0] acc_o,
    input wire logic zero_o,
    input wire logic skip_o
);
    default clocking cb @(posedge core_clk_i);
    endclocking
    default disable iff (rst_i);
    ////////////////////////////////////////////////////////////////////////////////
    // taken word that is not discarded and meets no bus write up to q4
    sequence s_quiet;
        !reg_wr_i ##1 (!skip_o && !reg_wr_i) ##1 !reg_wr_i [*2];
    endsequence
    sequence s_take_imm;
        phase_o == 2'h0 && instr_i[13:8] == isx_pkg::OPC_OR_IMM;
    endsequence
    sequence s_take_inc;
        phase_o == 2'h0 && instr_i[13:8] == isx_pkg::OPC_INC_SKIP;
    endsequence
    ////////////////////////////////////////////////////////////////////////////////
    // the first edge after reset still sees the reset phase as its past
    AST_PHASE_STEP: assert property (!$past(rst_i) |->
        phase_o == $past(phase_o) + 2'h1) else $error("phase did not advance");
    AST_ACC_HOLD: assert property (acc_o != $past(acc_o) |->
        $past(phase_o) == 2'h3 || $past(reg_wr_i && reg_addr_i == 8'h80))
        else $error("acc changed outside q4");
    AST_OR_IMM: assert property (s_take_imm ##0 s_quiet |=>
        acc_o == ($past(acc_o, 4) | 8'($past(instr_i, 4))) && zero_o == (acc_o == 8'h00))
        else $error("or immediate result wrong");
    AST_INC_NOFLAG: assert property (s_take_inc ##0 s_quiet |=>
        zero_o == $past(zero_o, 4)) else $error("increment touched zero flag");
    AST_INC_SKIP: assert property (s_take_inc ##0 (!instr_i[7]) ##0 s_quiet
        ##1 !reg_wr_i |=> skip_o == (acc_o == 8'h00))
        else $error("skip does not follow zero result");
    AST_SKIP_LEN: assert property ($rose(skip_o) |->
        (phase_o == 2'h1) ##0 skip_o [*3]) else $error("skip cycle too short");
    AST_SKIP_NOP: assert property (skip_o && phase_o == 2'h3 && !reg_wr_i
        |=> $stable(acc_o) && $stable(zero_o)) else $error("skipped word changed state");
    AST_RDATA_IDLE: assert property (!$past(reg_rd_i) |-> reg_rdata_o == 8'h00)
        else $error("read data without read");
    AST_RD_ACC: assert property (reg_rd_i && reg_addr_i == 8'h80 && phase_o != 2'h3
        |=> reg_rdata_o == $past(acc_o)) else $error("acc read back wrong");
endmodule : isx_monitor

bind isx_core isx_monitor u_mon (.core_clk_i, .rst_i, .instr_i, .reg_addr_i, .reg_wdata_i,
    .reg_wr_i, .reg_rd_i, .reg_rdata_o, .phase_o, .acc_o, .zero_o, .skip_o);

// ### bench/tb_top.sv
// self-checking bench for the three-instruction execute block
// assumes isx_core alone, driven straight at its ports
module tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    logic core_clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic [13:0] instr_i = 14'h0000;
    logic [7:0] reg_addr_i = 8'h00;
    logic [7:0] reg_wdata_i = 8'h00;
    logic reg_wr_i = 1'b0;
    logic reg_rd_i = 1'b0;
    logic [7:0] reg_rdata_o;
    logic [7:0] acc_o;
    logic [1:0] phase_o;
    logic zero_o;
    logic skip_o;
    logic [7:0] d; // last read data
    int fails = 0;
    int n_compared = 0;
    // 50 ns period
    always #25 core_clk_i = ~core_clk_i;
    isx_core dut (.core_clk_i, .rst_i, .instr_i, .reg_addr_i, .reg_wdata_i, .reg_wr_i,
        .reg_rd_i, .reg_rdata_o, .phase_o, .acc_o, .zero_o, .skip_o);
    ////////////////////////////////////////////////////////////////////////////////
    task give_verdict;
        $display("compared %0d mismatches %0d", n_compared, fails);
        if (fails == 0 && n_compared > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : give_verdict
    task chk8(input logic [7:0] got, input logic [7:0] exp);
        n_compared++;
        if (got !== exp)
        begin
            $display("[FAIL] %0t got %h exp %h", $time, got, exp);
            fails++;
        end
    endtask : chk8
    task chk1(input logic got, input logic exp);
        chk8({7'h00, got}, {7'h00, exp});
    endtask : chk1
    // bounded wait for a settled phase
    task sync(input logic [1:0] ph);
        int i;
        i = 0;
        do
        begin
            @(negedge core_clk_i);
            i++;
        end
        while (phase_o !== ph && i < 8);
        if (phase_o !== ph)
        begin
            fails++;
            give_verdict();
        end
    endtask : sync
    // present a word for the next q1, then a no-op behind it
    task exec(input logic [13:0] w);
        sync(2'h3);
        @(posedge core_clk_i);
        instr_i <= w;
        @(posedge core_clk_i);
        instr_i <= 14'h0000;
    endtask : exec
    task wr(input logic [7:0] a, input logic [7:0] v);
        @(posedge core_clk_i);
        reg_addr_i <= a;
        reg_wdata_i <= v;
        reg_wr_i <= 1'b1;
        @(posedge core_clk_i);
        reg_wr_i <= 1'b0;
    endtask : wr
    task rd(input logic [7:0] a);
        @(posedge core_clk_i);
        reg_addr_i <= a;
        reg_rd_i <= 1'b1;
        @(posedge core_clk_i);
        reg_rd_i <= 1'b0;
        @(negedge core_clk_i);
        d = reg_rdata_o;
    endtask : rd
    ////////////////////////////////////////////////////////////////////////////////
    initial
    begin
        repeat (8) @(posedge core_clk_i);
        rst_i <= 1'b0;
        rd(isx_pkg::ADDR_STATUS);
        chk8(d, 8'h00);
        // or-immediate: worked value, zero result, top literal
        wr(isx_pkg::ADDR_ACC, 8'h9a);
        exec(14'h3835);
        sync(2'h0);
        chk8(acc_o, 8'hbf);
        chk1(zero_o, 1'b0);
        wr(isx_pkg::ADDR_ACC, 8'h00);
        exec(14'h3800);
        sync(2'h0);
        chk1(zero_o, 1'b1);
        exec(14'h38ff);
        sync(2'h0);
        chk8(acc_o, 8'hff);
        // or-register into acc from the last file address
        wr(8'h7f, 8'h13);
        wr(isx_pkg::ADDR_ACC, 8'h91);
        exec(14'h047f);
        sync(2'h0);
        chk8(acc_o, 8'h93);
        rd(isx_pkg::ADDR_ACC);
        chk8(d, 8'h93);
        rd(8'h7f);
        chk8(d, 8'h13);
        // or-register back into the file, zero cleared
        wr(isx_pkg::ADDR_STATUS, 8'h01);
        wr(8'h05, 8'h40);
        wr(isx_pkg::ADDR_ACC, 8'h02);
        exec(14'h0485);
        sync(2'h0);
        chk1(zero_o, 1'b0);
        rd(8'h05);
        chk8(d, 8'h42);
        // increment into acc, flag kept, or-immediate right behind
        wr(isx_pkg::ADDR_STATUS, 8'h01);
        wr(8'h00, 8'h7f);
        exec(14'h0f00);
        exec(14'h3801);
        sync(2'h2);
        chk1(skip_o, 1'b0);
        chk1(zero_o, 1'b1);
        sync(2'h0);
        chk8(acc_o, 8'h81);
        // wrap to zero into the file discards the next word
        wr(8'h7f, 8'hff);
        wr(isx_pkg::ADDR_ACC, 8'h20);
        exec(14'h0fff);
        exec(14'h3801);
        sync(2'h2);
        chk1(skip_o, 1'b1);
        sync(2'h0);
        chk8(acc_o, 8'h20);
        rd(8'h7f);
        chk8(d, 8'h00);
        exec(14'h3801);
        sync(2'h0);
        chk8(acc_o, 8'h21);
        // wrap to zero into acc, file kept; the skip lands in the cycle after
        wr(8'h00, 8'hff);
        exec(14'h0f00);
        sync(2'h0);
        chk8(acc_o, 8'h00);
        sync(2'h2);
        chk1(skip_o, 1'b1);
        rd(isx_pkg::ADDR_STATUS);
        chk8(d, 8'h02);
        rd(8'h00);
        chk8(d, 8'hff);
        // foreign opcode does nothing; the taken word reads back
        exec(14'h30ff);
        rd(isx_pkg::ADDR_INSTR_LO);
        chk8(d, 8'hff);
        rd(isx_pkg::ADDR_INSTR_HI);
        chk8(d, 8'h30);
        sync(2'h0);
        chk8(acc_o, 8'h00);
        rd(8'h90);
        chk8(d, 8'h00);
        give_verdict();
    end
endmodule : tb_top
